/* core/nvac_pkg.sv */
// Package with register map, bit positions and timing for the non-volatile access controller
package nvac_pkg;
  localparam logic [3:0]  ADDR_CONTROL     = 4'h0;
  localparam logic [3:0]  ADDR_UNLOCK      = 4'h1;
  localparam logic [3:0]  ADDR_DATA_LOW    = 4'h2;
  localparam logic [3:0]  ADDR_DATA_HIGH   = 4'h3;
  localparam logic [3:0]  ADDR_ADDR_LOW    = 4'h4;
  localparam logic [3:0]  ADDR_ADDR_HIGH   = 4'h5;
  localparam logic [3:0]  ADDR_FLAGS       = 4'h6;
  localparam logic [3:0]  ADDR_PROTECT     = 4'h7;
  localparam int          BIT_READ         = 0;
  localparam int          BIT_WRITE        = 1;
  localparam int          BIT_ALLOW        = 2;
  localparam int          BIT_ABORT        = 3;
  localparam int          BIT_SPACE        = 7;
  localparam int          BIT_DONE         = 0;
  localparam logic [7:0]  UNLOCK_FIRST     = 8'h55;
  localparam logic [7:0]  UNLOCK_SECOND    = 8'haa;
  localparam logic [7:0]  DATA_ADDR_MASK   = 8'hff;
  localparam logic [7:0]  SMALL_ADDR_MASK  = 8'h7f;
  localparam logic [3:0]  PROG_HIGH_MASK   = 4'hf;
  localparam logic [5:0]  DATA_HIGH_MASK   = 6'h3f;
  localparam logic [7:0]  ERASED_BYTE      = 8'hff;
  localparam int          CLK_HZ           = 20000000;
  localparam int          WRITE_TIME_US    = 5000;
  localparam int          WRITE_CYCLES     = CLK_HZ / 1000000 * WRITE_TIME_US;
  localparam logic [16:0] WRITE_CYCLES_17  = 17'(WRITE_CYCLES);
  localparam logic [16:0] ERASE_CYCLES_17  = 17'(WRITE_CYCLES / 2);
  typedef enum logic [1:0] {
    NVAC_IDLE  = 2'b00,
    NVAC_READ  = 2'b01,
    NVAC_ERASE = 2'b10,
    NVAC_PROG  = 2'b11
  } nvac_state_e;
  typedef enum logic [1:0] {
    NVAC_LOCKED = 2'b00,
    NVAC_HALF   = 2'b01,
    NVAC_OPEN   = 2'b10
  } nvac_unlock_e;
endpackage : nvac_pkg

/* core/nvac_ctrl.sv */
// Indirect access controller for data non-volatile bytes and program flash words
//
// Local design decisions: the Wishbone register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module nvac_ctrl #(
  parameter logic [16:0] WRITE_CYCLES = nvac_pkg::WRITE_CYCLES_17,
  parameter logic [16:0] ERASE_CYCLES = nvac_pkg::ERASE_CYCLES_17,
  parameter bit          SMALL_DATA   = 1'b0
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        abort_reset_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [5:2]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        prg_req_i,
  input  wire logic        prg_we_i,
  input  wire logic        prg_space_i,
  input  wire logic [11:0] prg_addr_i,
  input  wire logic [13:0] prg_wdata_i,
  output logic      [13:0] prg_rdata_o,
  output logic             prg_ack_o,
  output logic             prg_denied_o,
  output logic             busy_o
);
  logic [7:0]  data_mem [0:255];
  logic [13:0] prog_mem [0:4095];
  logic [7:0]  nv_data_low;
  logic [5:0]  nv_data_high;
  logic [7:0]  nv_addr_low;
  logic [3:0]  nv_addr_high;
  logic        program_space_select;
  logic        write_allow;
  logic        write_abort_flag;
  logic        write_done_flag;
  logic        rd_trig;
  logic        wr_trig;
  logic        protect;
  logic [16:0] timer;
  nvac_pkg::nvac_state_e  state;
  nvac_pkg::nvac_unlock_e unlock;

  function automatic logic [7:0] data_index(input logic [7:0] a);
    data_index = SMALL_DATA ? (a & nvac_pkg::SMALL_ADDR_MASK) : (a & nvac_pkg::DATA_ADDR_MASK);
  endfunction : data_index

  function automatic logic [16:0] count_down(input logic [16:0] t);
    count_down = t - 17'h00001;
  endfunction : count_down

  wire        bus_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire        bus_wr    = bus_req && wb_we_i && wb_sel_i[0];
  wire        bus_rd    = bus_req && !wb_we_i;
  wire        wr_ctrl   = bus_wr && (wb_adr_i == nvac_pkg::ADDR_CONTROL);
  wire        wr_unlock = bus_wr && (wb_adr_i == nvac_pkg::ADDR_UNLOCK);
  wire        wr_dlow   = bus_wr && (wb_adr_i == nvac_pkg::ADDR_DATA_LOW);
  wire        wr_dhigh  = bus_wr && (wb_adr_i == nvac_pkg::ADDR_DATA_HIGH);
  wire        wr_alow   = bus_wr && (wb_adr_i == nvac_pkg::ADDR_ADDR_LOW);
  wire        wr_ahigh  = bus_wr && (wb_adr_i == nvac_pkg::ADDR_ADDR_HIGH);
  wire        wr_flags  = bus_wr && (wb_adr_i == nvac_pkg::ADDR_FLAGS);
  wire        wr_prot   = bus_wr && (wb_adr_i == nvac_pkg::ADDR_PROTECT);
  wire        idle      = (state == nvac_pkg::NVAC_IDLE);
  wire [7:0]  wb_byte   = wb_dat_i[7:0];
  wire        set_rd    = wr_ctrl && wb_byte[nvac_pkg::BIT_READ] && idle && !rd_trig;
  wire        wr_gate   = wb_byte[nvac_pkg::BIT_WRITE] && write_allow && !program_space_select;
  wire        set_wr    = wr_ctrl && idle && !rd_trig && !set_rd && wr_gate
                          && (unlock == nvac_pkg::NVAC_OPEN);
  wire        timer_end = (timer == 17'h00000);
  wire [7:0]  dat_idx   = data_index(nv_addr_low);
  wire [11:0] prg_idx   = {nv_addr_high, nv_addr_low};
  wire [7:0]  ctrl_rd   = {program_space_select, 3'h0, write_abort_flag, write_allow,
                           wr_trig, rd_trig};
  wire        ext_ok    = prg_req_i && !protect && idle && !rd_trig && !wr_trig;
  wire [7:0]  ext_didx  = data_index(prg_addr_i[7:0]);
  logic [7:0] rd_mux;
  logic                   next_rd_trig;
  logic                   next_wr_trig;
  logic [16:0]            next_timer;
  nvac_pkg::nvac_state_e  next_state;

  always_comb begin
    unique case (wb_adr_i)
      nvac_pkg::ADDR_CONTROL:   rd_mux = ctrl_rd;
      nvac_pkg::ADDR_UNLOCK:    rd_mux = 8'h00;
      nvac_pkg::ADDR_DATA_LOW:  rd_mux = nv_data_low;
      nvac_pkg::ADDR_DATA_HIGH: rd_mux = {2'h0, nv_data_high};
      nvac_pkg::ADDR_ADDR_LOW:  rd_mux = nv_addr_low;
      nvac_pkg::ADDR_ADDR_HIGH: rd_mux = {4'h0, nv_addr_high};
      nvac_pkg::ADDR_FLAGS:     rd_mux = {7'h00, write_done_flag};
      nvac_pkg::ADDR_PROTECT:   rd_mux = {7'h00, protect};
      default:                  rd_mux = 8'h00;
    endcase
  end

  // Bus slave: one registered ack a cycle after each request, unmapped offsets read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_rd ? {24'h000000, rd_mux} : 32'h00000000;
    end
  end

  // Unlock sequence: two patterns, then only a control write that is the very next bus write may trigger a write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      unlock <= nvac_pkg::NVAC_LOCKED;
    end else if (wr_unlock) begin
      if (wb_byte == nvac_pkg::UNLOCK_FIRST) begin
        unlock <= nvac_pkg::NVAC_HALF;
      end else if (wb_byte == nvac_pkg::UNLOCK_SECOND && unlock == nvac_pkg::NVAC_HALF) begin
        unlock <= nvac_pkg::NVAC_OPEN;
      end else begin
        unlock <= nvac_pkg::NVAC_LOCKED;
      end
    end else if (bus_wr) begin
      unlock <= nvac_pkg::NVAC_LOCKED;
    end
  end

  // Control bits and flags
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      program_space_select <= 1'b0;
      write_allow          <= 1'b0;
      protect              <= 1'b0;
      nv_addr_low          <= 8'h00;
      nv_addr_high         <= 4'h0;
    end else begin
      if (wr_ctrl) begin
        program_space_select <= wb_byte[nvac_pkg::BIT_SPACE];
        write_allow          <= wb_byte[nvac_pkg::BIT_ALLOW];
      end
      if (wr_alow) begin
        nv_addr_low <= wb_byte;
      end
      if (wr_ahigh) begin
        nv_addr_high <= wb_byte[3:0] & nvac_pkg::PROG_HIGH_MASK;
      end
      if (wr_prot) begin
        protect <= protect | wb_byte[0];
      end
    end
  end

  // Abort flag survives pin and watchdog resets; other resets clear it
  always_ff @(posedge clk_i) begin
    if (rst_i && abort_reset_i) begin
      if (wr_trig) begin
        write_abort_flag <= 1'b1;
      end
    end else if (rst_i) begin
      write_abort_flag <= 1'b0;
    end else if (wr_ctrl && !wb_byte[nvac_pkg::BIT_ABORT]) begin
      write_abort_flag <= 1'b0;
    end
  end

  // Done flag: completion beats a same-cycle software clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      write_done_flag <= 1'b0;
    end else if (state == nvac_pkg::NVAC_PROG && timer_end) begin
      write_done_flag <= 1'b1;
    end else if (wr_flags && !wb_byte[nvac_pkg::BIT_DONE]) begin
      write_done_flag <= 1'b0;
    end
  end

  // Access sequencer: next state, triggers and internal write timer
  always_comb begin
    next_state   = state;
    next_rd_trig = rd_trig;
    next_wr_trig = wr_trig;
    next_timer   = timer;
    unique case (state)
      nvac_pkg::NVAC_IDLE: begin
        if (set_rd) begin
          next_rd_trig = 1'b1;
          next_state   = nvac_pkg::NVAC_READ;
        end else if (set_wr) begin
          next_wr_trig = 1'b1;
          next_timer   = ERASE_CYCLES;
          next_state   = nvac_pkg::NVAC_ERASE;
        end
      end
      nvac_pkg::NVAC_READ: begin
        next_rd_trig = 1'b0;
        next_state   = nvac_pkg::NVAC_IDLE;
      end
      nvac_pkg::NVAC_ERASE: begin
        if (timer_end) begin
          next_timer = WRITE_CYCLES;
          next_state = nvac_pkg::NVAC_PROG;
        end else begin
          next_timer = count_down(timer);
        end
      end
      nvac_pkg::NVAC_PROG: begin
        if (timer_end) begin
          next_wr_trig = 1'b0;
          next_state   = nvac_pkg::NVAC_IDLE;
        end else begin
          next_timer = count_down(timer);
        end
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state   <= nvac_pkg::NVAC_IDLE;
      rd_trig <= 1'b0;
      wr_trig <= 1'b0;
      timer   <= 17'h00000;
    end else begin
      state   <= next_state;
      rd_trig <= next_rd_trig;
      wr_trig <= next_wr_trig;
      timer   <= next_timer;
    end
  end

  // Data registers: software writes, the read cycle loads the addressed location
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nv_data_low  <= 8'h00;
      nv_data_high <= 6'h00;
    end else begin
      if (wr_dlow) begin
        nv_data_low <= wb_byte;
      end
      if (wr_dhigh) begin
        nv_data_high <= wb_byte[5:0] & nvac_pkg::DATA_HIGH_MASK;
      end
      if (state == nvac_pkg::NVAC_READ && program_space_select) begin
        nv_data_low  <= prog_mem[prg_idx][7:0];
        nv_data_high <= prog_mem[prg_idx][13:8];
      end else if (state == nvac_pkg::NVAC_READ) begin
        nv_data_low <= data_mem[dat_idx];
      end
    end
  end

  // Memory arrays, reached only through the registers or the programmer port
  always_ff @(posedge clk_i) begin
    if (!rst_i && state == nvac_pkg::NVAC_ERASE && timer_end) begin
      data_mem[dat_idx] <= nvac_pkg::ERASED_BYTE;
    end else if (!rst_i && state == nvac_pkg::NVAC_PROG && timer_end) begin
      data_mem[dat_idx] <= nv_data_low;
    end else if (!rst_i && ext_ok && prg_we_i && !prg_space_i) begin
      data_mem[ext_didx] <= prg_wdata_i[7:0];
    end
  end

  // Program flash loads only through the unprotected programmer port
  always_ff @(posedge clk_i) begin
    if (!rst_i && ext_ok && prg_we_i && prg_space_i) begin
      prog_mem[prg_addr_i] <= prg_wdata_i;
    end
  end

  // External programmer port, refused while protected
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prg_rdata_o  <= 14'h0000;
      prg_ack_o    <= 1'b0;
      prg_denied_o <= 1'b0;
      busy_o       <= 1'b0;
    end else begin
      prg_ack_o    <= ext_ok;
      prg_denied_o <= prg_req_i && protect;
      busy_o       <= !idle || set_rd || set_wr;
      if (ext_ok && !prg_we_i) begin
        prg_rdata_o <= prg_space_i ? prog_mem[prg_addr_i] : {6'h00, data_mem[ext_didx]};
      end else if (prg_req_i && protect) begin
        prg_rdata_o <= 14'h0000;
      end
    end
  end
endmodule : nvac_ctrl
`default_nettype wire

/* verification/nvac_ctrl_asserts.sv */
// Assertion checker for the non-volatile access controller
`timescale 1ns/10ps
`default_nettype none
module nvac_ctrl_asserts #(
  parameter logic [16:0] WRITE_CYCLES = 17'h14,
  parameter logic [16:0] ERASE_CYCLES = 17'ha
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [5:2]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [31:0] wb_dat_o,
  input  wire logic        wb_ack_o,
  input  wire logic        prg_req_i,
  input  wire logic        prg_ack_o,
  input  wire logic        prg_denied_o,
  input  wire logic        busy_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic        prot_take;
  logic        prot_done;
  logic [16:0] busy_cnt;
  wire         prot_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_dat_i[0]
                         && wb_adr_i == nvac_pkg::ADDR_PROTECT;
  // Protection seen at the take edge and at the ack edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prot_take <= 1'b0;
      prot_done <= 1'b0;
      busy_cnt  <= '0;
    end else begin
      prot_take <= prot_take | (prot_wr & ~wb_ack_o);
      prot_done <= prot_done | (prot_wr & wb_ack_o);
      busy_cnt  <= busy_o ? busy_cnt + 17'h1 : '0;
    end
  end
  sequence req_taken;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence ack_once;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  ack_timing_a: assert property (req_taken |=> ack_once)
    else $error("bus ack not one cycle after request");
  stray_ack_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("bus ack without request");
  unlock_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == nvac_pkg::ADDR_UNLOCK
    |-> wb_dat_o == 32'h0) else $error("unlock port read not zero");
  read_width_a: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read bits not zero");
  deny_prot_a: assert property (prot_done && prg_req_i |=> prg_denied_o && !prg_ack_o)
    else $error("programmer not denied under protection");
  open_access_a: assert property (!prot_take && prg_req_i |=> prg_ack_o && !prg_denied_o)
    else $error("programmer refused without protection");
  prg_cause_a: assert property (prg_ack_o || prg_denied_o |-> $past(prg_req_i))
    else $error("programmer answer without request");
  write_time_a: assert property ($fell(busy_o)
    |-> busy_cnt < 17'h4 || busy_cnt >= ERASE_CYCLES + WRITE_CYCLES)
    else $error("write time shorter than timer");
endmodule : nvac_ctrl_asserts
bind nvac_ctrl nvac_ctrl_asserts #(.WRITE_CYCLES(WRITE_CYCLES), .ERASE_CYCLES(ERASE_CYCLES)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .prg_req_i(prg_req_i), .prg_ack_o(prg_ack_o), .prg_denied_o(prg_denied_o), .busy_o(busy_o));
`default_nettype wire

/* verification/tb_nvac_ctrl.sv */
// Self-checking testbench for the non-volatile access controller
`timescale 1ns/10ps
`default_nettype none
module tb_nvac_ctrl;
  logic        clk_i = 1'b0, rst_i = 1'b1, abort_reset_i = 1'b0;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [5:2]  wb_adr_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic        wb_ack_o, prg_req_i = 1'b0, prg_ack_o, prg_denied_o, busy_o;
  logic [11:0] prg_addr_i = 12'h0;
  logic [3:0]  wb_sel_i = 4'hf;
  logic        prg_we_i = 1'b0, prg_space_i = 1'b0;
  logic [13:0] prg_rdata_o, prg_wdata_i = 14'h0, w;
  logic [32:0] notes[$], nt;
  logic [7:0]  a, d;
  int          errors = 0, checks_done = 0, ticks = 0;
  always #25 clk_i = ~clk_i;
  nvac_ctrl #(.WRITE_CYCLES(17'h14), .ERASE_CYCLES(17'ha)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .abort_reset_i(abort_reset_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .prg_req_i(prg_req_i),
    .prg_we_i(prg_we_i), .prg_space_i(prg_space_i), .prg_addr_i(prg_addr_i),
    .prg_wdata_i(prg_wdata_i),
    .prg_rdata_o(prg_rdata_o), .prg_ack_o(prg_ack_o), .prg_denied_o(prg_denied_o),
    .busy_o(busy_o));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic summarize();
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  task automatic bus(input logic we, input logic [3:0] adr, input logic [7:0] dat);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= {24'h0, dat};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 40);
    if (n >= 40) errors++;
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : bus
  task automatic wr(input logic [3:0] adr, input logic [7:0] dat);
    bus(1'b1, adr, dat);
  endtask : wr
  task automatic rd(input logic [3:0] adr, input logic [7:0] exp);
    notes.push_back({1'b1, 24'h0, exp});
    bus(1'b0, adr, 8'h0);
  endtask : rd
  task automatic unlock();
    wr(nvac_pkg::ADDR_UNLOCK, nvac_pkg::UNLOCK_FIRST);
    wr(nvac_pkg::ADDR_UNLOCK, nvac_pkg::UNLOCK_SECOND);
  endtask : unlock
  // Poll control until both triggers are back to zero
  task automatic poll();
    repeat (60) begin
      notes.push_back(33'h0);
      bus(1'b0, nvac_pkg::ADDR_CONTROL, 8'h0);
      if (q[nvac_pkg::BIT_READ] === 1'b0 && q[nvac_pkg::BIT_WRITE] === 1'b0) break;
    end
  endtask : poll
  task automatic probe(input logic we, input logic sp, input logic [11:0] ad,
                       input logic [13:0] wd);
    prg_we_i    <= we;
    prg_space_i <= sp;
    prg_addr_i  <= ad;
    prg_wdata_i <= wd;
    prg_req_i   <= 1'b1;
    @(posedge clk_i);
    prg_req_i <= 1'b0;
    prg_we_i  <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask : probe
  // Result watcher and run limit
  always @(posedge clk_i) begin
    ticks++;
    if (ticks > 5000) begin
      errors++;
      summarize();
    end
    if (!rst_i && ((wb_ack_o === 1'b1 && !wb_we_i) || prg_ack_o === 1'b1
                   || prg_denied_o === 1'b1)) begin
      if (notes.size() == 0) errors++;
      else begin
        nt = notes.pop_front();
        if (nt[32] && wb_ack_o === 1'b1) check(wb_dat_o, nt[31:0]);
        else if (nt[32]) check({16'h0, prg_denied_o, prg_ack_o, prg_rdata_o}, nt[31:0]);
      end
    end
  end
  initial begin
    void'($urandom(32'h276b));
    a = 8'($urandom());
    d = 8'($urandom());
    w = 14'($urandom());
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(nvac_pkg::ADDR_CONTROL, 8'h00);
    rd(nvac_pkg::ADDR_UNLOCK, 8'h00);
    wr(nvac_pkg::ADDR_ADDR_LOW, a);
    wr(nvac_pkg::ADDR_DATA_LOW, d);
    wb_sel_i <= 4'he;
    wr(nvac_pkg::ADDR_DATA_LOW, ~d);
    wb_sel_i <= 4'hf;
    rd(nvac_pkg::ADDR_DATA_LOW, d);
    unlock();
    wr(nvac_pkg::ADDR_CONTROL, 8'h02);
    rd(nvac_pkg::ADDR_CONTROL, 8'h00);
    wr(nvac_pkg::ADDR_CONTROL, 8'h04);
    wr(nvac_pkg::ADDR_CONTROL, 8'h06);
    rd(nvac_pkg::ADDR_CONTROL, 8'h04);
    unlock();
    wr(nvac_pkg::ADDR_CONTROL, 8'h06);
    wr(nvac_pkg::ADDR_CONTROL, 8'h04);
    rd(nvac_pkg::ADDR_CONTROL, 8'h06);
    poll();
    rd(nvac_pkg::ADDR_CONTROL, 8'h04);
    rd(nvac_pkg::ADDR_FLAGS, 8'h01);
    wr(nvac_pkg::ADDR_FLAGS, 8'h00);
    rd(nvac_pkg::ADDR_FLAGS, 8'h00);
    wr(nvac_pkg::ADDR_DATA_LOW, ~d);
    wr(nvac_pkg::ADDR_CONTROL, 8'h05);
    poll();
    rd(nvac_pkg::ADDR_DATA_LOW, d);
    notes.push_back({1'b1, 16'h0, 2'b01, 6'h00, d});
    probe(1'b0, 1'b0, {4'h0, a}, 14'h0000);
    notes.push_back(33'h0);
    probe(1'b1, 1'b1, {d[3:0], a}, w);
    notes.push_back({1'b1, 16'h0, 2'b01, w});
    probe(1'b0, 1'b1, {d[3:0], a}, 14'h0000);
    wr(nvac_pkg::ADDR_ADDR_HIGH, {4'h0, d[3:0]});
    rd(nvac_pkg::ADDR_ADDR_HIGH, {4'h0, d[3:0]});
    wr(nvac_pkg::ADDR_CONTROL, 8'h85);
    poll();
    rd(nvac_pkg::ADDR_DATA_LOW, w[7:0]);
    rd(nvac_pkg::ADDR_DATA_HIGH, {2'h0, w[13:8]});
    wr(nvac_pkg::ADDR_CONTROL, 8'h84);
    unlock();
    wr(nvac_pkg::ADDR_CONTROL, 8'h86);
    rd(nvac_pkg::ADDR_CONTROL, 8'h84);
    wr(nvac_pkg::ADDR_CONTROL, 8'h04);
    wr(nvac_pkg::ADDR_PROTECT, 8'h01);
    notes.push_back({1'b1, 16'h0, 2'b10, 14'h0000});
    probe(1'b0, 1'b0, {4'h0, a}, 14'h0000);
    wr(nvac_pkg::ADDR_DATA_LOW, 8'h00);
    wr(nvac_pkg::ADDR_CONTROL, 8'h05);
    poll();
    rd(nvac_pkg::ADDR_DATA_LOW, d);
    unlock();
    wr(nvac_pkg::ADDR_CONTROL, 8'h06);
    repeat (5) @(posedge clk_i);
    rst_i         <= 1'b1;
    abort_reset_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i         <= 1'b0;
    abort_reset_i <= 1'b0;
    @(posedge clk_i);
    rd(nvac_pkg::ADDR_CONTROL, 8'h08);
    wr(nvac_pkg::ADDR_CONTROL, 8'h00);
    rd(nvac_pkg::ADDR_CONTROL, 8'h00);
    summarize();
  end
endmodule : tb_nvac_ctrl
`default_nettype wire
